// *** shared/abu_pkg.sv ***
package abu_pkg;

	// register indices on the 8-bit register port
	localparam logic [2:0] ABU_OFF_CTRL   = 3'h0;
	localparam logic [2:0] ABU_OFF_ADDRH  = 3'h1;
	localparam logic [2:0] ABU_OFF_ADDRL  = 3'h2;
	localparam logic [2:0] ABU_OFF_AUX    = 3'h3;
	localparam logic [2:0] ABU_OFF_WSTAT  = 3'h4;
	localparam logic [2:0] ABU_OFF_FCLR   = 3'h5;

	// field positions
	localparam int ABU_BIT_ENABLE   = 7;
	localparam int ABU_BIT_ACTIVE   = 6;
	localparam int ABU_BIT_WDOG_DIS = 0;
	localparam int ABU_BIT_WAIT_EXIT = 1;
	localparam int ABU_BIT_CLR_EN   = 7;

	// reset values
	localparam logic [7:0]  ABU_RST_BYTE = 8'h00;
	localparam logic [15:0] ABU_RST_ADDR = 16'h0000;

	// vectors and opcodes
	localparam logic [15:0] ABU_VEC_NORMAL  = 16'hFFFC;
	localparam logic [15:0] ABU_VEC_MONITOR = 16'hFEFC;
	localparam logic [7:0]  ABU_OPC_SWI     = 8'h83;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} abu_reg_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        pc_cycle;
		logic        opcode_fetch;
		logic        insn_start;
		logic        rti_done;
		logic        low_power;
	} abu_cpu_bus_t;

	typedef enum logic [1:0] {
		ABU_IDLE    = 2'b00,
		ABU_PENDING = 2'b01,
		ABU_BREAK   = 2'b10
	} abu_state_t;

endpackage : abu_pkg

// *** core/abu_breakpoint_unit.sv ***
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps

// Overview of operation
// - enabled address match raises breakpoint request
// - compare only program-counter generated addresses
// - break substitutes software interrupt opcode
// - vector FFFC normally, FEFC in monitor
// - interrupt return ends break state
// - opcode match breaks before instruction executes
// - operand match breaks after instruction completes
// - writing active bit breaks before next instruction
// - enable bit 7, read/write, reset clears
// - active set by match, software/reset clear
// - address bytes readable writable, reset clears
// - unchanged address after clear gives no rebreak
// - new address plus clear re-arms breaks
// - break stops timer and blocks captures
// - monitor break disables watchdog when bit set
// - flag shows wait exited by break
// - flags clearable in break only when enabled
// - no match break in wait or stop
module abu_breakpoint_unit (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 arst_n,
	// register port
	input  wire abu_pkg::abu_reg_req_t reg_req,
	output logic [7:0]                reg_rdata,
	// cpu side
	input  wire abu_pkg::abu_cpu_bus_t cpu_bus,
	input  wire logic                 monitor_mode,
	input  wire logic                 wait_exit_wake,
	// system integration side
	output logic                      breakpoint_request,
	output logic                      force_swi,
	output logic [7:0]                swi_opcode,
	output logic [15:0]               break_vector,
	output logic                      break_state,
	// gating of other modules
	output logic                      timer_stop,
	output logic                      capture_inhibit,
	output logic                      watchdog_disable,
	output logic                      flag_clear_allow
);
	import abu_pkg::*;

	abu_state_t  state_reg;
	abu_state_t  state_next;
	logic        enable_reg;
	logic        active_reg;
	logic [15:0] baddr_reg;
	logic        wdog_dis_reg;
	logic        clr_en_reg;
	logic        wait_exit_reg;
	logic        rearm_reg;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] o,
		input logic s);
		hit = s && (a == o);
	endfunction : hit

	logic wr_ctrl;
	logic sw_break;
	logic match;
	logic opc_match;
	logic opr_match;
	logic take;

	assign wr_ctrl  = hit(reg_req.addr, ABU_OFF_CTRL, reg_req.wr);
	assign sw_break = wr_ctrl && reg_req.wdata[ABU_BIT_ACTIVE];
	// a stale address stays disarmed until an address byte is rewritten or reset
	assign match = enable_reg && rearm_reg && cpu_bus.pc_cycle
		&& !cpu_bus.low_power && (cpu_bus.addr == baddr_reg);
	assign opc_match = match && cpu_bus.opcode_fetch;
	assign opr_match = match && !cpu_bus.opcode_fetch;
	// break taken only at an instruction boundary
	assign take = (state_reg == ABU_PENDING) && cpu_bus.insn_start;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ABU_IDLE:
			begin
				if (opc_match)
					state_next = ABU_BREAK;
				else if (opr_match || sw_break)
					state_next = ABU_PENDING;
			end
			ABU_PENDING:
			begin
				if (take)
					state_next = ABU_BREAK;
			end
			ABU_BREAK:
			begin
				if (cpu_bus.rti_done)
					state_next = ABU_IDLE;
			end
			default:
				state_next = ABU_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			state_reg <= ABU_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			enable_reg <= 1'b0;
		else if (wr_ctrl)
			enable_reg <= reg_req.wdata[ABU_BIT_ENABLE];
	end

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			active_reg <= 1'b0;
		else if (match || sw_break)
			active_reg <= 1'b1;
		else if (wr_ctrl)
			active_reg <= reg_req.wdata[ABU_BIT_ACTIVE];
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			baddr_reg <= ABU_RST_ADDR;
		else
		begin
			if (hit(reg_req.addr, ABU_OFF_ADDRH, reg_req.wr))
				baddr_reg[15:8] <= reg_req.wdata;
			if (hit(reg_req.addr, ABU_OFF_ADDRL, reg_req.wr))
				baddr_reg[7:0] <= reg_req.wdata;
		end
	end

	// a hit disarms; writing a new address re-arms
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			rearm_reg <= 1'b1;
		else if (match)
			rearm_reg <= 1'b0;
		else if (hit(reg_req.addr, ABU_OFF_ADDRH, reg_req.wr)
			|| hit(reg_req.addr, ABU_OFF_ADDRL, reg_req.wr))
			rearm_reg <= 1'b1;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wdog_dis_reg <= 1'b0;
			clr_en_reg   <= 1'b0;
		end
		else
		begin
			if (hit(reg_req.addr, ABU_OFF_AUX, reg_req.wr))
				wdog_dis_reg <= reg_req.wdata[ABU_BIT_WDOG_DIS];
			if (hit(reg_req.addr, ABU_OFF_FCLR, reg_req.wr))
				clr_en_reg <= reg_req.wdata[ABU_BIT_CLR_EN];
		end
	end

	// wait-exit flag: set by a wake from wait that enters break
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			wait_exit_reg <= 1'b0;
		else if (wait_exit_wake && state_next == ABU_BREAK
			&& state_reg != ABU_BREAK)
			wait_exit_reg <= 1'b1;
		else if (hit(reg_req.addr, ABU_OFF_WSTAT, reg_req.wr)
			&& !reg_req.wdata[ABU_BIT_WAIT_EXIT])
			wait_exit_reg <= 1'b0;
		else if (state_reg == ABU_IDLE && !wait_exit_wake)
			wait_exit_reg <= wait_exit_reg;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= ABU_RST_BYTE;
		else
		begin
			reg_rdata <= ABU_RST_BYTE;
			if (reg_req.rd)
				case (reg_req.addr)
					ABU_OFF_CTRL:
						reg_rdata <= {enable_reg, active_reg, 6'h00};
					ABU_OFF_ADDRH:
						reg_rdata <= baddr_reg[15:8];
					ABU_OFF_ADDRL:
						reg_rdata <= baddr_reg[7:0];
					ABU_OFF_AUX:
						reg_rdata <= {7'h00, wdog_dis_reg};
					ABU_OFF_WSTAT:
						reg_rdata <= {6'h00, wait_exit_reg, 1'b0};
					ABU_OFF_FCLR:
						reg_rdata <= {clr_en_reg, 7'h00};
					default:
						reg_rdata <= ABU_RST_BYTE;
				endcase
		end
	end

	// outputs other than the vector and opcode registered from next state so they align with break entry
	logic entering;
	assign entering = (state_next == ABU_BREAK) && (state_reg != ABU_BREAK);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			breakpoint_request <= 1'b0;
			force_swi          <= 1'b0;
			swi_opcode         <= ABU_OPC_SWI;
			break_vector       <= ABU_VEC_NORMAL;
			break_state        <= 1'b0;
			timer_stop         <= 1'b0;
			capture_inhibit    <= 1'b0;
			watchdog_disable   <= 1'b0;
			flag_clear_allow   <= 1'b1;
		end
		else
		begin
			breakpoint_request <= entering;
			force_swi          <= entering;
			swi_opcode         <= ABU_OPC_SWI;
			break_vector       <= monitor_mode ? ABU_VEC_MONITOR
				: ABU_VEC_NORMAL;
			break_state        <= (state_next == ABU_BREAK);
			timer_stop         <= (state_next == ABU_BREAK);
			capture_inhibit    <= (state_next == ABU_BREAK);
			watchdog_disable   <= (state_next == ABU_BREAK)
				&& monitor_mode && wdog_dis_reg;
			flag_clear_allow   <= (state_next != ABU_BREAK)
				|| clr_en_reg;
		end
	end

	// assertions
	sequence s_opc_hit;
		match && cpu_bus.opcode_fetch && state_reg == ABU_IDLE;
	endsequence

	sequence s_enter;
		breakpoint_request && force_swi && break_state;
	endsequence

	property p_opc_break;
		@(posedge clk_sys) disable iff (!arst_n)
		s_opc_hit |=> s_enter;
	endproperty
	a_opc_break: assert property (p_opc_break)
		else $error("opcode match did not enter break next cycle");

	property p_no_match_disabled;
		@(posedge clk_sys) disable iff (!arst_n)
		(!enable_reg && state_reg == ABU_IDLE && !sw_break) |=> !break_state;
	endproperty
	a_no_match_disabled: assert property (p_no_match_disabled)
		else $error("break entered while disabled");

	property p_rti_ends;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_reg == ABU_BREAK && cpu_bus.rti_done) |=> !break_state;
	endproperty
	a_rti_ends: assert property (p_rti_ends)
		else $error("return did not end break");

	property p_sw_break;
		@(posedge clk_sys) disable iff (!arst_n)
		(sw_break && !opc_match && state_reg == ABU_IDLE)
			|=> (state_reg == ABU_PENDING && !break_state);
	endproperty
	a_sw_break: assert property (p_sw_break)
		else $error("software break did not wait for next instruction");

	property p_active_set;
		@(posedge clk_sys) disable iff (!arst_n)
		match |=> active_reg;
	endproperty
	a_active_set: assert property (p_active_set)
		else $error("active bit not set on match");

	property p_timer_gate;
		@(posedge clk_sys) disable iff (!arst_n)
		break_state |-> (timer_stop && capture_inhibit);
	endproperty
	a_timer_gate: assert property (p_timer_gate)
		else $error("timer not stopped during break");

	property p_wdog;
		@(posedge clk_sys) disable iff (!arst_n)
		watchdog_disable |-> (break_state && $past(wdog_dis_reg)
			&& $past(monitor_mode));
	endproperty
	a_wdog: assert property (p_wdog)
		else $error("watchdog disabled without cause");

	property p_low_power;
		@(posedge clk_sys) disable iff (!arst_n)
		cpu_bus.low_power |-> !match;
	endproperty
	a_low_power: assert property (p_low_power)
		else $error("match during low power");

	property p_flag_clear;
		@(posedge clk_sys) disable iff (!arst_n)
		(break_state && !$past(clr_en_reg)) |-> !flag_clear_allow;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag clear allowed during break without enable");

	property p_vector;
		@(posedge clk_sys) disable iff (!arst_n)
		$past(monitor_mode) |-> break_vector == ABU_VEC_MONITOR;
	endproperty
	a_vector: assert property (p_vector)
		else $error("wrong break vector in monitor mode");

	property p_take;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_reg == ABU_PENDING && cpu_bus.insn_start) |=> s_enter;
	endproperty
	a_take: assert property (p_take)
		else $error("pending break not entered at instruction start");

	property p_pend_hold;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_reg == ABU_PENDING && !cpu_bus.insn_start) |=> !break_state;
	endproperty
	a_pend_hold: assert property (p_pend_hold)
		else $error("pending break entered before instruction start");

	property p_no_rebreak;
		@(posedge clk_sys) disable iff (!arst_n)
		(!rearm_reg && state_reg == ABU_IDLE && !sw_break) |=> !break_state;
	endproperty
	a_no_rebreak: assert property (p_no_rebreak)
		else $error("disarmed address broke again");

	property p_req_pulse;
		@(posedge clk_sys) disable iff (!arst_n)
		breakpoint_request |=> !breakpoint_request;
	endproperty
	a_req_pulse: assert property (p_req_pulse)
		else $error("breakpoint request longer than one cycle");

	property p_active_clear;
		@(posedge clk_sys) disable iff (!arst_n)
		(wr_ctrl && !reg_req.wdata[ABU_BIT_ACTIVE] && !match) |=> !active_reg;
	endproperty
	a_active_clear: assert property (p_active_clear)
		else $error("active bit not cleared by software");

	property p_enable_write;
		@(posedge clk_sys) disable iff (!arst_n)
		wr_ctrl |=> (enable_reg == $past(reg_req.wdata[ABU_BIT_ENABLE]));
	endproperty
	a_enable_write: assert property (p_enable_write)
		else $error("enable bit does not follow write");

	property p_wait_exit;
		@(posedge clk_sys) disable iff (!arst_n)
		(wait_exit_wake && entering) |=> wait_exit_reg;
	endproperty
	a_wait_exit: assert property (p_wait_exit)
		else $error("wait exit by break not flagged");

endmodule : abu_breakpoint_unit

// *** tb/abu_cpu_model.sv ***
`timescale 1ns/10ps

module abu_cpu_model (
	// clock
	input  wire logic                  clk_sys,
	// bus toward the unit
	output abu_pkg::abu_cpu_bus_t      cpu_bus,
	input  wire logic                  break_state,
	// length of the break routine in cycles
	input  wire logic [3:0]            rti_wait
);
	import abu_pkg::*;

	int          cnt = 0;
	logic        rti_q = 1'b0;
	logic [15:0] addr_q = 16'h0000;
	logic        opc_q = 1'b0;
	logic        pc_q = 1'b0;
	logic        lp_q = 1'b0;
	logic        st_q = 1'b0;

	// one driver per field: the bus is only assembled here
	assign cpu_bus = '{addr: addr_q, pc_cycle: pc_q, opcode_fetch: opc_q,
		insn_start: st_q, rti_done: rti_q, low_power: lp_q};

	// routine length set by the bench: prompt and slow returns
	always @(posedge clk_sys)
	begin
		cnt <= break_state ? cnt + 1 : 0;
		rti_q <= break_state && cnt == int'(rti_wait);
	end

	// one bus cycle, then a released bus that shows an inverted address
	task automatic cyc(input logic [15:0] a, input logic opc,
		input logic pc, input logic lp, input logic st);
		@(posedge clk_sys);
		{addr_q, opc_q} <= {a, opc};
		{pc_q, lp_q} <= {pc, lp};
		st_q <= st;
		@(posedge clk_sys);
		{addr_q, opc_q} <= {~a, 1'b0};
		{pc_q, lp_q} <= 2'b00;
		st_q <= 1'b0;
	endtask : cyc

endmodule : abu_cpu_model

// *** tb/abu_breakpoint_unit_bench.sv ***
`timescale 1ns/10ps

module abu_breakpoint_unit_bench;
	import abu_pkg::*;

	logic         clk_sys = 1'b0;
	logic         arst_n = 1'b0;
	abu_reg_req_t reg_req = '0;
	logic [7:0]   reg_rdata;
	abu_cpu_bus_t cpu_bus;
	logic         mon = 1'b0;
	logic         wake = 1'b0;
	logic [3:0]   rti_wait = 4'hF;
	logic         bp_req, f_swi, breakpoint_unit, t_stop, cap_inh, wd_dis, fc_ok;
	logic [7:0]   swi_op;
	logic [15:0]  vec;
	int           failures = 0;
	int           check_count = 0;
	int           cycles = 0;

	always #5 clk_sys = ~clk_sys;

	abu_breakpoint_unit dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .cpu_bus(cpu_bus),
		.monitor_mode(mon), .wait_exit_wake(wake),
		.breakpoint_request(bp_req), .force_swi(f_swi),
		.swi_opcode(swi_op), .break_vector(vec), .break_state(breakpoint_unit),
		.timer_stop(t_stop), .capture_inhibit(cap_inh),
		.watchdog_disable(wd_dis), .flag_clear_allow(fc_ok));

	abu_cpu_model u_cpu (.clk_sys(clk_sys), .cpu_bus(cpu_bus),
		.break_state(breakpoint_unit), .rti_wait(rti_wait));

	task automatic chk(input logic [15:0] act, input logic [15:0] exp);
		check_count++;
		if (act !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, act, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		reg_req.wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		reg_req.rd <= 1'b0;
		@(negedge clk_sys);
		chk(reg_rdata, e);
	endtask : rd_chk

	task automatic wait_end();
		for (int i = 0; i < 40 && breakpoint_unit !== 1'b0; i++)
			@(negedge clk_sys);
		chk(breakpoint_unit, 1'b0);
	endtask : wait_end

	task automatic test_done();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	// a hang is cut short well beyond the roughly 110 cycles needed
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures++;
			test_done();
		end
	end

	initial
	begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(negedge clk_sys);
		chk(fc_ok, 1'b1);
		chk(vec, ABU_VEC_NORMAL);
		for (int i = 0; i < 7; i++)
			rd_chk(3'(i), ABU_RST_BYTE);
		$display("test reset done");
		wr(ABU_OFF_ADDRH, 8'h12);
		wr(ABU_OFF_ADDRL, 8'h34);
		wr(ABU_OFF_AUX, 8'h01);
		wr(ABU_OFF_FCLR, 8'h80);
		wr(3'h6, 8'hFF);
		rd_chk(ABU_OFF_ADDRH, 8'h12);
		rd_chk(ABU_OFF_ADDRL, 8'h34);
		rd_chk(ABU_OFF_AUX, 8'h01);
		rd_chk(ABU_OFF_FCLR, 8'h80);
		rd_chk(3'h6, 8'h00);
		$display("test registers done");
		u_cpu.cyc(16'h1234, 1'b1, 1'b1, 1'b0, 1'b0);
		@(negedge clk_sys);
		chk(breakpoint_unit, 1'b0);
		wr(ABU_OFF_CTRL, 8'h80);
		rd_chk(ABU_OFF_CTRL, 8'h80);
		u_cpu.cyc(16'h1234, 1'b1, 1'b0, 1'b0, 1'b0);
		@(negedge clk_sys);
		chk(breakpoint_unit, 1'b0);
		u_cpu.cyc(16'h1234, 1'b1, 1'b1, 1'b1, 1'b0);
		@(negedge clk_sys);
		chk(breakpoint_unit, 1'b0);
		@(posedge clk_sys);
		{mon, wake} <= 2'b11;
		u_cpu.cyc(16'h1234, 1'b1, 1'b1, 1'b0, 1'b0);
		@(negedge clk_sys);
		chk({bp_req, f_swi, swi_op}, {2'b11, ABU_OPC_SWI});
		chk(vec, ABU_VEC_MONITOR);
		chk({breakpoint_unit, t_stop, cap_inh}, 3'b111);
		chk({wd_dis, fc_ok}, 2'b11);
		@(posedge clk_sys);
		wake <= 1'b0;
		@(negedge clk_sys);
		chk(bp_req, 1'b0);
		rd_chk(ABU_OFF_CTRL, 8'hC0);
		rd_chk(ABU_OFF_WSTAT, 8'h02);
		wr(ABU_OFF_CTRL, 8'h80);
		wait_end();
		rd_chk(ABU_OFF_CTRL, 8'h80);
		wr(ABU_OFF_WSTAT, 8'h00);
		rd_chk(ABU_OFF_WSTAT, 8'h00);
		u_cpu.cyc(16'h1234, 1'b1, 1'b1, 1'b0, 1'b0);
		@(negedge clk_sys);
		chk(breakpoint_unit, 1'b0);
		$display("test address break done");
		@(posedge clk_sys);
		mon <= 1'b0;
		wr(ABU_OFF_ADDRL, 8'h36);
		u_cpu.cyc(16'h1236, 1'b0, 1'b1, 1'b0, 1'b0);
		@(negedge clk_sys);
		chk(breakpoint_unit, 1'b0);
		u_cpu.cyc(16'h1237, 1'b0, 1'b1, 1'b0, 1'b1);
		@(negedge clk_sys);
		chk(breakpoint_unit, 1'b1);
		chk({vec, wd_dis}, {ABU_VEC_NORMAL, 1'b0});
		rd_chk(ABU_OFF_WSTAT, 8'h00);
		wr(ABU_OFF_FCLR, 8'h00);
		repeat (2) @(negedge clk_sys);
		chk(fc_ok, 1'b0);
		wr(ABU_OFF_CTRL, 8'h80);
		wait_end();
		chk(fc_ok, 1'b1);
		$display("test operand break done");
		@(posedge clk_sys);
		rti_wait <= 4'h2;
		wr(ABU_OFF_CTRL, 8'hC0);
		@(negedge clk_sys);
		chk(breakpoint_unit, 1'b0);
		u_cpu.cyc(16'h2000, 1'b1, 1'b1, 1'b0, 1'b1);
		@(negedge clk_sys);
		chk(breakpoint_unit, 1'b1);
		wait_end();
		$display("test software break done");
		test_done();
	end

endmodule : abu_breakpoint_unit_bench
